//--- common/sbgt_params.svh
`ifndef SBGT_PARAMS_SVH
`define SBGT_PARAMS_SVH

// register byte offsets
`define SBGT_OFF_CTRL       8'h00
`define SBGT_OFF_COUNT      8'h04
`define SBGT_OFF_PERIOD     8'h08
`define SBGT_OFF_STATUS     8'h0c
`define SBGT_OFF_MASK       8'h10

// control word field positions
`define SBGT_BIT_RUN        15
`define SBGT_BIT_IDLE_STOP  13
`define SBGT_BIT_GATE_EN    6
`define SBGT_BIT_PS_HI      5
`define SBGT_BIT_PS_LO      4
`define SBGT_BIT_SYNC       2
`define SBGT_BIT_SRC        1
`define SBGT_CTRL_WMASK     16'ha076

// status / mask bit positions
`define SBGT_ST_MATCH       0
`define SBGT_ST_GATE        1

// reset values
`define SBGT_RST_CTRL       16'h0000
`define SBGT_RST_COUNT      16'h0000
`define SBGT_RST_PERIOD     16'hffff
`define SBGT_RST_IRQ        2'h0

// prescaler terminal counts (divide minus one)
`define SBGT_DIV1_LIMIT     8'h00
`define SBGT_DIV8_LIMIT     8'h07
`define SBGT_DIV64_LIMIT    8'h3f
`define SBGT_DIV256_LIMIT   8'hff

// axi responses
`define SBGT_RESP_OKAY      2'h0
`define SBGT_RESP_SLVERR    2'h2

`endif

//--- common/sbgt_pkg.sv
package sbgt_pkg;

    typedef struct packed {
        logic       run_enable;
        logic       idle_stop;
        logic       gate_accumulate_en;
        logic [1:0] prescale_select;
        logic       ext_clock_sync;
        logic       clock_source_select;
    } sbgt_ctrl_t;

    typedef enum logic [1:0] {
        SRC_INTERNAL,
        SRC_GATED,
        SRC_EXT_SYNC,
        SRC_EXT_ASYNC
    } sbgt_src_t;

    typedef struct packed {
        logic       gate_fall;
        logic       match;
    } sbgt_evt_t;

endpackage

//--- design/sbgt_timer.sv
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ns
// Behaviour
// - 16-bit count; internal timer, synced external counter, unsynced external counter.
// - interrupt on count equal period, and on gate falling edge when gated.
// - control bit 13 set halts the unit during idle; clear keeps running.
// - bit 6 counts only while gate high, internal clock only.
// - bits 5-4 divide input by 1, 8, 64 or 256.
// - bit 2 picks synced or unsynced external clock; ignored when internal.
// - unimplemented control bits ignore writes and read zero.
// - unit may keep running in idle, subject to idle stop; in sleep only the unsynced external counter runs.
module sbgt_timer
    import sbgt_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        EXT_CLOCK_PIN,
    input  wire logic        IDLE_MODE,
    input  wire logic        SLEEP_MODE,
    output logic             IRQ,
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY
);
`include "sbgt_params.svh"

    function automatic logic [15:0] apply_strb(input logic [15:0] old_val,
                                               input logic [31:0] data,
                                               input logic [3:0]  strb);
        return {strb[1] ? data[15:8] : old_val[15:8], strb[0] ? data[7:0] : old_val[7:0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // registers and state
    logic [15:0] ctrl_reg;
    logic [15:0] count_reg;
    logic [15:0] period_reg;
    logic [1:0]  status_reg;
    logic [1:0]  mask_reg;
    logic [7:0]  pre_cnt_reg;
    logic        ext_meta_reg;
    logic        ext_sync_reg;
    logic        ext_prev_reg;
    logic        aw_hold_reg;
    logic [7:0]  aw_addr_reg;
    logic        w_hold_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // control decode
    sbgt_ctrl_t  ctrl;
    sbgt_src_t   src_mode;
    sbgt_evt_t   evt;
    logic        ext_rise;
    logic        gate_fall;
    logic        halted;
    logic        src_event;
    logic [7:0]  pre_limit;
    logic        pre_tick;
    logic        is_match;
    logic [15:0] count_next;
    logic [1:0]  status_next;
    assign ctrl.run_enable          = ctrl_reg[`SBGT_BIT_RUN];
    assign ctrl.idle_stop           = ctrl_reg[`SBGT_BIT_IDLE_STOP];
    assign ctrl.gate_accumulate_en  = ctrl_reg[`SBGT_BIT_GATE_EN];
    assign ctrl.prescale_select     = ctrl_reg[`SBGT_BIT_PS_HI:`SBGT_BIT_PS_LO];
    assign ctrl.ext_clock_sync      = ctrl_reg[`SBGT_BIT_SYNC];
    assign ctrl.clock_source_select = ctrl_reg[`SBGT_BIT_SRC];

    // gate only applies to the internal clock, sync only to the pin
    assign src_mode = !ctrl.clock_source_select ?
                      (ctrl.gate_accumulate_en ? SRC_GATED : SRC_INTERNAL) :
                      (ctrl.ext_clock_sync ? SRC_EXT_SYNC : SRC_EXT_ASYNC);

    // the pin always passes two flops; unsynced mode differs by surviving sleep
    assign ext_rise  = ext_sync_reg & ~ext_prev_reg;
    assign gate_fall = ~ext_sync_reg & ext_prev_reg;

    // sleep stops every source but the unsynced pin clock; the two pin flops keep running in sleep
    assign halted = !ctrl.run_enable
                  | (IDLE_MODE & ctrl.idle_stop)
                  | (SLEEP_MODE & (src_mode != SRC_EXT_ASYNC));

    always_comb begin
        case (src_mode)
            SRC_INTERNAL:  src_event = 1'b1;
            SRC_GATED:     src_event = ext_sync_reg;
            SRC_EXT_SYNC:  src_event = ext_rise;
            SRC_EXT_ASYNC: src_event = ext_rise;
            default:       src_event = 1'b0;
        endcase
    end

    assign pre_limit = (ctrl.prescale_select == 2'b00) ? `SBGT_DIV1_LIMIT :
                       (ctrl.prescale_select == 2'b01) ? `SBGT_DIV8_LIMIT :
                       (ctrl.prescale_select == 2'b10) ? `SBGT_DIV64_LIMIT :
                                                         `SBGT_DIV256_LIMIT;

    assign pre_tick   = !halted & src_event & (pre_cnt_reg >= pre_limit);
    assign is_match   = (count_reg == period_reg);
    assign count_next = is_match ? 16'h0000 : count_reg + 16'h0001;
    assign evt.match     = pre_tick & is_match;
    assign evt.gate_fall = !halted & (src_mode == SRC_GATED) & gate_fall;

    ////////////////////////////////////////////////////////////////////////////////
    // register bus decode
    logic do_write;
    logic wr_ctrl;
    logic wr_count;
    logic wr_period;
    logic wr_status;
    logic wr_mask;
    logic wr_hit;
    logic rd_take;
    logic rd_hit;
    logic [31:0] rd_data;
    logic [1:0]  w1c_bits;
    assign do_write  = aw_hold_reg & w_hold_reg & ~bvalid_reg;
    assign wr_ctrl   = do_write & (aw_addr_reg == `SBGT_OFF_CTRL);
    assign wr_count  = do_write & (aw_addr_reg == `SBGT_OFF_COUNT);
    assign wr_period = do_write & (aw_addr_reg == `SBGT_OFF_PERIOD);
    assign wr_status = do_write & (aw_addr_reg == `SBGT_OFF_STATUS);
    assign wr_mask   = do_write & (aw_addr_reg == `SBGT_OFF_MASK);
    assign wr_hit    = wr_ctrl | wr_count | wr_period | wr_status | wr_mask;
    assign w1c_bits  = (wr_status & w_strb_reg[0]) ? w_data_reg[1:0] : 2'h0;

    // a hardware event in the clearing cycle survives the clear
    assign status_next = (status_reg & ~w1c_bits) | {evt.gate_fall, evt.match};
    assign rd_take = S_AXI_ARVALID & ~rvalid_reg;
    assign rd_hit  = (S_AXI_ARADDR == `SBGT_OFF_CTRL)   | (S_AXI_ARADDR == `SBGT_OFF_COUNT)
                   | (S_AXI_ARADDR == `SBGT_OFF_PERIOD) | (S_AXI_ARADDR == `SBGT_OFF_STATUS)
                   | (S_AXI_ARADDR == `SBGT_OFF_MASK);
    assign rd_data = (S_AXI_ARADDR == `SBGT_OFF_CTRL)   ? {16'h0000, ctrl_reg} :
                     (S_AXI_ARADDR == `SBGT_OFF_COUNT)  ? {16'h0000, count_reg} :
                     (S_AXI_ARADDR == `SBGT_OFF_PERIOD) ? {16'h0000, period_reg} :
                     (S_AXI_ARADDR == `SBGT_OFF_STATUS) ? {30'h0, status_reg} :
                     (S_AXI_ARADDR == `SBGT_OFF_MASK)   ? {30'h0, mask_reg} : 32'h0000_0000;
    assign S_AXI_AWREADY = ~aw_hold_reg;
    assign S_AXI_WREADY  = ~w_hold_reg;
    assign S_AXI_ARREADY = ~rvalid_reg;
    assign S_AXI_BVALID  = bvalid_reg;
    assign S_AXI_BRESP   = bresp_reg;
    assign S_AXI_RVALID  = rvalid_reg;
    assign S_AXI_RDATA   = rdata_reg;
    assign S_AXI_RRESP   = rresp_reg;
    assign IRQ           = |(status_reg & mask_reg);

    ////////////////////////////////////////////////////////////////////////////////
    // bus slave state
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            aw_hold_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
        end else if (S_AXI_AWVALID && !aw_hold_reg) begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= S_AXI_AWADDR;
        end else if (do_write) begin
            aw_hold_reg <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            w_hold_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else if (S_AXI_WVALID && !w_hold_reg) begin
            w_hold_reg <= 1'b1;
            w_data_reg <= S_AXI_WDATA;
            w_strb_reg <= S_AXI_WSTRB;
        end else if (do_write) begin
            w_hold_reg <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= `SBGT_RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_hit ? `SBGT_RESP_OKAY : `SBGT_RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            bvalid_reg <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= `SBGT_RESP_OKAY;
        end else if (rd_take) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_data;
            rresp_reg  <= rd_hit ? `SBGT_RESP_OKAY : `SBGT_RESP_SLVERR;
        end else if (S_AXI_RREADY) begin
            rvalid_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // timer core
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ctrl_reg   <= `SBGT_RST_CTRL;
            period_reg <= `SBGT_RST_PERIOD;
            mask_reg   <= `SBGT_RST_IRQ;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= apply_strb(ctrl_reg, w_data_reg, w_strb_reg) & `SBGT_CTRL_WMASK;
            end
            if (wr_period) begin
                period_reg <= apply_strb(period_reg, w_data_reg, w_strb_reg);
            end
            if (wr_mask && w_strb_reg[0]) begin
                mask_reg <= w_data_reg[1:0];
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ext_meta_reg <= 1'b0;
            ext_sync_reg <= 1'b0;
            ext_prev_reg <= 1'b0;
        end else begin
            ext_meta_reg <= EXT_CLOCK_PIN;
            ext_sync_reg <= ext_meta_reg;
            ext_prev_reg <= ext_sync_reg;
        end
    end

    // prescaler restarts whenever the run bit is clear so the first tick is a full period; idle or sleep halts only hold it
    always_ff @(posedge CLK) begin
        if (!RST_N || !ctrl.run_enable) begin
            pre_cnt_reg <= 8'h00;
        end else if (pre_tick) begin
            pre_cnt_reg <= 8'h00;
        end else if (!halted && src_event) begin
            pre_cnt_reg <= pre_cnt_reg + 8'h01;
        end
    end

    // a software count write beats a tick in the same cycle
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            count_reg  <= `SBGT_RST_COUNT;
            status_reg <= `SBGT_RST_IRQ;
        end else begin
            if (wr_count) begin
                count_reg <= apply_strb(count_reg, w_data_reg, w_strb_reg);
            end else if (pre_tick) begin
                count_reg <= count_next;
            end
            status_reg <= status_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    property p_match_wrap;
        (pre_tick && is_match && !wr_count) |=> (count_reg == 16'h0000) && status_reg[`SBGT_ST_MATCH];
    endproperty
    a_match_wrap: assert property (p_match_wrap) else $error("count did not wrap on match");
    property p_gate_irq;
        (evt.gate_fall && !wr_status) |=> status_reg[`SBGT_ST_GATE];
    endproperty
    a_gate_irq: assert property (p_gate_irq) else $error("gate falling edge lost");
    property p_stopped;
        (!ctrl.run_enable && !wr_count) |=> (count_reg == $past(count_reg));
    endproperty
    a_stopped: assert property (p_stopped) else $error("count moved while stopped");
    property p_idle_halt;
        (IDLE_MODE && ctrl.idle_stop) |-> !pre_tick;
    endproperty
    a_idle_halt: assert property (p_idle_halt) else $error("tick during idle stop");
    property p_gate_low;
        (src_mode == SRC_GATED && !ext_sync_reg) |-> !pre_tick;
    endproperty
    a_gate_low: assert property (p_gate_low) else $error("gated count with gate low");
    property p_div8;
        (pre_tick && ctrl.prescale_select == 2'b01 && !wr_ctrl) |=> (!pre_tick)[*7];
    endproperty
    a_div8: assert property (p_div8) else $error("divide by 8 ticked early");
    property p_sync_sleep;
        (SLEEP_MODE && src_mode == SRC_EXT_SYNC) |-> !pre_tick;
    endproperty
    a_sync_sleep: assert property (p_sync_sleep) else $error("synced counter ran in sleep");
    property p_int_source;
        (src_mode == SRC_INTERNAL && ctrl.prescale_select == 2'b00 && !halted) |-> pre_tick;
    endproperty
    a_int_source: assert property (p_int_source) else $error("internal clock missed a tick");
    property p_unimpl_zero;
        (ctrl_reg & ~`SBGT_CTRL_WMASK) == 16'h0000;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented control bit set");
    property p_async_sleep;
        (SLEEP_MODE && src_mode == SRC_EXT_ASYNC && ctrl.run_enable && !(IDLE_MODE && ctrl.idle_stop)
         && ext_rise && ctrl.prescale_select == 2'b00) |-> pre_tick;
    endproperty
    a_async_sleep: assert property (p_async_sleep) else $error("unsynced counter stalled in sleep");

    c_match:      cover property (evt.match && mask_reg[`SBGT_ST_MATCH]);
    c_gate_fall:  cover property (evt.gate_fall);
    c_async_run:  cover property (SLEEP_MODE && pre_tick);
    c_set_clear:  cover property (wr_status && w1c_bits[0] && evt.match);

endmodule

//--- dv/sbgt_pin_source.sv
`timescale 1ns/1ns
module sbgt_pin_source (
    input  wire logic clk,
    output logic      pin
);
    // pin rests low between bursts, so no stray edge reaches the counter
    initial pin = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////
    // clock bursts: one rising edge every 8 cycles, slow enough for the two-flop sync
    task automatic pulses(input int n);
        repeat (n) begin
            pin <= 1'b1;
            repeat (4) @(posedge clk);
            pin <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask

    // gate window: high for len cycles, then the falling edge
    task automatic gate(input int len);
        pin <= 1'b1;
        repeat (len) @(posedge clk);
        pin <= 1'b0;
    endtask
endmodule

//--- dv/sbgt_tb.sv
`timescale 1ns/1ns
`include "sbgt_params.svh"
module testbench
    import sbgt_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        idle = 1'b0;
    logic        sleep = 1'b0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        arvalid = 1'b0;
    logic        bready = 1'b1;
    logic        rready = 1'b1;
    logic [3:0]  wstrb = 4'hf;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]  bresp, rresp, rs;
    logic [31:0] rdata, rd;
    wire         ext_pin;
    int          err_total = 0;
    int          compares = 0;
    int          sh [4] = '{0, 3, 6, 8};
    logic [31:0] xc [3] = '{32'h8046, 32'h8046, 32'h8042};
    logic [31:0] xe [3] = '{32'd20, 32'd0, 32'd20};

    always #25 clk = ~clk;

    sbgt_timer uut (.CLK(clk), .RST_N(rst_n), .EXT_CLOCK_PIN(ext_pin), .IDLE_MODE(idle), .SLEEP_MODE(sleep),
        .IRQ(irq), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    sbgt_pin_source src (.clk(clk), .pin(ext_pin));

    ////////////////////////////////////////////////////////////////////////////////
    // bus tasks: handshakes judged at the negedge, where readies are settled
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        tb = 1'b0;
        while (!tb) begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            rs = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
    endtask

    task automatic axr(input logic [7:0] a);
        logic ta, td;
        araddr <= a;
        arvalid <= 1'b1;
        td = 1'b0;
        while (!td) begin
            @(negedge clk);
            ta = arvalid && arready;
            td = rvalid;
            rd = rdata;
            rs = rresp;
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // counts crossing a bus write carry a few cycles of slack
    task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi, input string what);
        compares++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            err_total++;
            $display("MISMATCH t=%0t %s got %0d want %0d..%0d", $time, what, got, lo, hi);
        end
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string what);
        axr(a);
        chk(rd, exp, what);
    endtask

    task automatic ci(input logic exp);
        @(negedge clk);
        chk({31'h0, irq}, {31'h0, exp}, "irq level");
        @(posedge clk);
    endtask

    task automatic run_span(input logic [31:0] c, input int cyc);
        axw(`SBGT_OFF_COUNT, 32'h0);
        axw(`SBGT_OFF_CTRL, c);
        repeat (cyc) @(posedge clk);
        axw(`SBGT_OFF_CTRL, 32'h0);
        axr(`SBGT_OFF_COUNT);
    endtask

    task automatic print_verdict;
        $display("counts: compares=%0d mismatches=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rc(`SBGT_OFF_CTRL, 32'h0, "ctrl reset");
        chk({30'h0, rs}, 32'h0, "mapped read resp");
        rc(`SBGT_OFF_COUNT, 32'h0, "count reset");
        rc(`SBGT_OFF_PERIOD, 32'hffff, "period reset");
        rc(`SBGT_OFF_STATUS, 32'h0, "status reset");
        rc(`SBGT_OFF_MASK, 32'h0, "mask reset");
        ci(1'b0);
        $display("test reset done");
        axw(`SBGT_OFF_CTRL, 32'hffff_ffff);
        chk({30'h0, rs}, 32'h0, "mapped write resp");
        rc(`SBGT_OFF_CTRL, 32'h0000_a076, "ctrl unimplemented bits");
        axw(`SBGT_OFF_CTRL, 32'h0);
        axw(8'h20, 32'h1);
        chk({30'h0, rs}, 32'h2, "unmapped write resp");
        axr(8'h20);
        chk({30'h0, rs}, 32'h2, "unmapped read resp");
        chk(rd, 32'h0, "unmapped read data");
        $display("test registers done");
        // one span per divider code; the span is a multiple of 256 so all codes are exact
        for (int p = 0; p < 4; p++) begin
            run_span(32'h8000 | (p << 4), 2560);
            chk_rng(rd, 2560 >> sh[p], ((2572) >> sh[p]) + 1, "prescaled count");
        end
        $display("test prescale done");
        axw(`SBGT_OFF_STATUS, 32'h3);
        axw(`SBGT_OFF_MASK, 32'h1);
        axw(`SBGT_OFF_PERIOD, 32'h4);
        axw(`SBGT_OFF_COUNT, 32'h0);
        axw(`SBGT_OFF_CTRL, 32'h8000);
        repeat (20) @(posedge clk);
        ci(1'b1);
        axr(`SBGT_OFF_COUNT);
        chk_rng(rd, 0, 4, "count wraps at period");
        axw(`SBGT_OFF_MASK, 32'h0);
        ci(1'b0);
        axw(`SBGT_OFF_CTRL, 32'h0);
        rc(`SBGT_OFF_STATUS, 32'h1, "match flag");
        axw(`SBGT_OFF_STATUS, 32'h1);
        rc(`SBGT_OFF_STATUS, 32'h0, "match flag cleared");
        axw(`SBGT_OFF_PERIOD, 32'hffff);
        $display("test match done");
        idle <= 1'b1;
        run_span(32'ha000, 100);
        chk(rd, 32'h0, "halted in idle");
        run_span(32'h8000, 100);
        chk_rng(rd, 100, 106, "runs in idle");
        idle <= 1'b0;
        sleep <= 1'b1;
        run_span(32'h8000, 100);
        chk(rd, 32'h0, "internal halted in sleep");
        sleep <= 1'b0;
        $display("test power modes done");
        // synced, synced in sleep, unsynced in sleep; gate bit set but ignored
        for (int k = 0; k < 3; k++) begin
            axw(`SBGT_OFF_STATUS, 32'h3);
            axw(`SBGT_OFF_COUNT, 32'h0);
            sleep <= (k != 0);
            axw(`SBGT_OFF_CTRL, xc[k]);
            src.pulses(20);
            repeat (8) @(posedge clk);
            axw(`SBGT_OFF_CTRL, 32'h0);
            sleep <= 1'b0;
            rc(`SBGT_OFF_COUNT, xe[k], "external edges counted");
            rc(`SBGT_OFF_STATUS, 32'h0, "gate ignored with external clock");
        end
        $display("test external clock done");
        axw(`SBGT_OFF_STATUS, 32'h3);
        axw(`SBGT_OFF_MASK, 32'h2);
        axw(`SBGT_OFF_COUNT, 32'h0);
        axw(`SBGT_OFF_CTRL, 32'h8040);
        src.gate(200);
        repeat (8) @(posedge clk);
        axw(`SBGT_OFF_CTRL, 32'h0);
        axr(`SBGT_OFF_COUNT);
        chk_rng(rd, 198, 202, "gated accumulation");
        rc(`SBGT_OFF_STATUS, 32'h2, "gate fall flag");
        ci(1'b1);
        axw(`SBGT_OFF_STATUS, 32'h2);
        ci(1'b0);
        $display("test gated done");
        print_verdict();
    end

    // whole run is near 11500 cycles; over three times that means a hang
    initial begin
        repeat (40000) @(posedge clk);
        err_total++;
        print_verdict();
    end
endmodule
